// [rtl/aus_pkg.sv]
// Constants and types shared by the four-channel audio synthesizer output block
// Overview of operation
// RULE_01: Four channels, each speech or melody, played back by hardware without software.
// RULE_02: Mixer sums one to four channels as chosen by channel_mix_select.
// RULE_03: Speech channel has play flag, pointer, decoder, quick-io code, 8-bit 1MHz timer.
// RULE_04: Speech decoder accepts raw PCM and ADPCM encoded data.
// RULE_05: Melody channel has play flag, pointer, timer, envelope, skipper and multiplier.
// RULE_06: Timbre skipper steps over waveform points to reach higher octaves.
// RULE_07: Melody multiplier is internal only and no instruction can reach it.
// RULE_08: audio_output_select chooses PWM stage or DAC stage.
// RULE_09: At reset, floating audio_pad_two sets audio_output_select to PWM.
// RULE_10: At reset, audio_pad_two tied high sets audio_output_select to DAC.
// RULE_11: Software keeps audio_output_select unchanged when relying on pad detection.
// RULE_12: Sixteen-step output_volume scales audio to both PWM and DAC stages.
// RULE_13: Pad one carries PWM one or DAC; pad two carries PWM two.
// RULE_14: Audio control registers have no address, only special instructions reach them.
// RULE_15: PWM stage has 9-bit resolution, DAC stage 10-bit resolution.
// RULE_16: Melody envelope offers 256 steps.
// RULE_17: Sample playback rate programmable up to 44.1kHz at most.
// RULE_18: Four-bit output_volume, larger codes louder, applied before the output stage.
`default_nettype none
package aus_pkg;
	localparam int CLK_HZ = 40_000_000;
	localparam int TIMER_HZ = 1_000_000;
	localparam int TICK_DIV = CLK_HZ / TIMER_HZ;
	localparam int MAX_RATE_HZ = 44100;
	localparam int TIMER_MIN = (TIMER_HZ + MAX_RATE_HZ - 1) / MAX_RATE_HZ;
	localparam int NUM_CH = 4;
	localparam int ADDR_W = 18;
	localparam int ROM_W = 10;
	localparam int SMP_W = 9;
	localparam int TMR_W = 8;
	localparam int ENV_W = 8;
	localparam int VOL_W = 4;
	localparam int MIX_W = 11;
	localparam int PWM_W = 9;
	localparam int DAC_W = 10;
	localparam int DETECT_CYCLES = 16;
	localparam logic [ROM_W-1:0] END_MARK = 10'h3ff;
	localparam logic [5:0] QIO_TAG = 6'h3e;
	localparam logic [2:0] STEP_MAX = 3'h7;
	localparam logic [DAC_W-1:0] DAC_MID = 10'h200;
	localparam logic [DAC_W-1:0] DAC_POS_MAX = 10'h1ff;
	localparam logic [DAC_W-1:0] DAC_NEG_MAX = 10'h200;
	localparam logic [VOL_W-1:0] VOL_RESET = 4'hf;
	localparam logic [1:0] MIX_RESET = 2'h3;

	typedef enum logic [2:0] {
		AUS_OP_MIX,
		AUS_OP_AUD,
		AUS_OP_VOL,
		AUS_OP_CFG,
		AUS_OP_START,
		AUS_OP_STOP,
		AUS_OP_ENV
	} aus_op_t;

	typedef enum logic {AUS_OUT_PWM, AUS_OUT_DAC} aus_out_t;

	typedef struct packed {
		logic valid;
		aus_op_t op;
		logic [1:0] chan;
		logic [ADDR_W-1:0] arg;
	} aus_instr_t;

	typedef struct packed {
		logic melody;
		logic adpcm;
		logic [3:0] skip;
		logic [TMR_W-1:0] rate;
	} aus_cfg_t;

	localparam int CFG_W = $bits(aus_cfg_t);
endpackage
`default_nettype wire

// [rtl/aus_channel.sv]
// One synthesis channel: sample timer, voice pointer, speech decoder, melody datapath
`default_nettype none
module aus_channel (
	input wire logic sys_clk_in,
	input wire logic rst_in,
	input wire logic tick_in,
	input wire logic cfg_we_in,
	input wire logic start_we_in,
	input wire logic stop_in,
	input wire logic env_we_in,
	input wire logic [aus_pkg::ADDR_W-1:0] arg_in,
	input wire logic grant_in,
	input wire logic rom_valid_in,
	input wire logic [aus_pkg::ROM_W-1:0] rom_data_in,
	output logic play_flag_out,
	output logic rom_req_out,
	output logic [aus_pkg::ADDR_W-1:0] rom_addr_out,
	output logic signed [aus_pkg::SMP_W-1:0] sample_out,
	output logic [3:0] quick_io_code_out,
	output logic quick_io_strobe_out
);
	aus_pkg::aus_cfg_t cfg_q;
	logic play_q;
	logic due_q;
	logic wait_q;
	logic [aus_pkg::TMR_W-1:0] timer_q;
	logic [aus_pkg::ADDR_W-1:0] ptr_q;
	logic [aus_pkg::ENV_W-1:0] env_q;
	logic [2:0] step_q;
	logic signed [aus_pkg::SMP_W-1:0] smp_q;
	logic [3:0] qio_q;
	logic qio_stb_q;

	// ****************************************
	// Decode of one fetched word
	// ****************************************
	logic [aus_pkg::TMR_W-1:0] reload;
	logic is_end;
	logic is_qio;
	logic [aus_pkg::ADDR_W-1:0] ptr_step;
	logic signed [aus_pkg::SMP_W-1:0] raw;
	logic signed [aus_pkg::SMP_W+aus_pkg::ENV_W:0] prod;
	logic signed [aus_pkg::SMP_W-1:0] melody_smp;
	logic [aus_pkg::MIX_W-1:0] delta;
	logic signed [aus_pkg::MIX_W-1:0] pred;
	logic signed [aus_pkg::SMP_W-1:0] adpcm_smp;
	logic [2:0] step_d;

	// Rate is clamped so the timer never fires faster than the top sample rate
	assign reload = (cfg_q.rate < aus_pkg::TMR_W'(aus_pkg::TIMER_MIN)) ?
		aus_pkg::TMR_W'(aus_pkg::TIMER_MIN - 1) : cfg_q.rate - 8'h01; // RULE_17
	assign is_end = (rom_data_in == aus_pkg::END_MARK);
	assign is_qio = !cfg_q.melody && (rom_data_in[9:4] == aus_pkg::QIO_TAG); // RULE_03
	assign ptr_step = cfg_q.melody ? aus_pkg::ADDR_W'(cfg_q.skip) + 18'h00001 : 18'h00001; // RULE_06
	assign raw = signed'(rom_data_in[aus_pkg::ROM_W-1:1]);
	// Envelope multiplier sits only in this datapath
	assign prod = raw * signed'({1'b0, env_q}); // RULE_05 RULE_07 RULE_16
	assign melody_smp = prod[aus_pkg::SMP_W+aus_pkg::ENV_W-1:aus_pkg::ENV_W];
	assign delta = aus_pkg::MIX_W'({rom_data_in[2:0], 1'b1}) << step_q;
	assign pred = rom_data_in[3] ? aus_pkg::MIX_W'(smp_q) - signed'(delta) :
		aus_pkg::MIX_W'(smp_q) + signed'(delta);
	assign adpcm_smp = (pred > 11'sd255) ? 9'sd255 : (pred < -11'sd256) ? -9'sd256 :
		pred[aus_pkg::SMP_W-1:0]; // RULE_04
	assign step_d = (rom_data_in[2:0] >= 3'h6 && step_q != aus_pkg::STEP_MAX) ? step_q + 3'h1 :
		(rom_data_in[2:0] < 3'h2 && step_q != 3'h0) ? step_q - 3'h1 : step_q;

	assign play_flag_out = play_q;
	assign rom_req_out = play_q && due_q && !wait_q; // RULE_01
	assign rom_addr_out = ptr_q;
	assign sample_out = smp_q;
	assign quick_io_code_out = qio_q;
	assign quick_io_strobe_out = qio_stb_q;

	// ****************************************
	// Control and sample state
	// ****************************************
	always_ff @(posedge sys_clk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			cfg_q <= '0;
			play_q <= 1'b0;
			due_q <= 1'b0;
			wait_q <= 1'b0;
			timer_q <= '0;
			ptr_q <= '0;
			env_q <= '0;
			step_q <= '0;
			smp_q <= '0;
			qio_q <= '0;
			qio_stb_q <= 1'b0;
		end
		else
		begin
			qio_stb_q <= 1'b0;
			if (cfg_we_in)
				cfg_q <= aus_pkg::aus_cfg_t'(arg_in[aus_pkg::CFG_W-1:0]);
			if (env_we_in)
				env_q <= arg_in[aus_pkg::ENV_W-1:0]; // RULE_16
			// Grant clears first so a tick in the same cycle still marks a new sample
			if (grant_in)
			begin
				wait_q <= 1'b1;
				due_q <= 1'b0;
			end
			if (tick_in && play_q)
			begin
				timer_q <= (timer_q == '0) ? reload : timer_q - 8'h01; // RULE_03
				if (timer_q == '0)
					due_q <= 1'b1;
			end
			if (rom_valid_in)
			begin
				wait_q <= 1'b0;
				if (is_end)
					play_q <= 1'b0;
				else
				begin
					ptr_q <= ptr_q + ptr_step;
					if (is_qio)
					begin
						qio_q <= rom_data_in[3:0];
						qio_stb_q <= 1'b1;
						due_q <= 1'b1;
					end
					else if (cfg_q.melody)
						smp_q <= melody_smp;
					else if (cfg_q.adpcm)
					begin
						smp_q <= adpcm_smp;
						step_q <= step_d;
					end
					else
						smp_q <= raw;
				end
			end
			if (start_we_in)
			begin
				play_q <= 1'b1;
				ptr_q <= arg_in;
				due_q <= 1'b1;
				timer_q <= reload;
				step_q <= '0;
				smp_q <= '0;
			end
			else if (stop_in)
				play_q <= 1'b0;
		end
	end
endmodule
`default_nettype wire

// [rtl/aus_synth.sv]
// Top of the audio synthesizer: instruction port, mixer, volume, PWM and DAC stages
`default_nettype none
module aus_synth #(
	parameter int NUM_CH = aus_pkg::NUM_CH,
	parameter int DETECT_CYCLES = aus_pkg::DETECT_CYCLES
) (
	input wire logic sys_clk_in,
	input wire logic rst_in,
	input wire aus_pkg::aus_instr_t instr_in,
	output logic rom_rd_out,
	output logic [aus_pkg::ADDR_W-1:0] rom_addr_out,
	input wire logic [aus_pkg::ROM_W-1:0] rom_data_in,
	output logic [NUM_CH-1:0] play_flag_out,
	output logic [3:0] quick_io_code_out,
	output logic quick_io_strobe_out,
	output logic audio_output_select_out,
	output logic detect_busy_out,
	output logic audio_pad_one_out,
	input wire logic audio_pad_two_in,
	output logic audio_pad_two_out,
	output logic audio_pad_two_oe_n_out,
	output logic pad_two_pulldown_out,
	output logic dac_enable_out,
	output logic [aus_pkg::DAC_W-1:0] dac_code_out
);
	typedef enum logic {AUS_ST_SENSE, AUS_ST_RUN} aus_state_t;

	aus_state_t state_q;
	logic [$clog2(DETECT_CYCLES+1)-1:0] det_cnt_q;
	logic pad_meta_q;
	logic pad_sync_q;
	aus_pkg::aus_out_t aud_q;
	logic [1:0] mix_q;
	logic [aus_pkg::VOL_W-1:0] vol_q;
	logic [$clog2(aus_pkg::TICK_DIV)-1:0] div_q;
	logic tick_q;
	logic [NUM_CH-1:0] valid_q;
	logic [aus_pkg::PWM_W-1:0] pwm_cnt_q;
	logic pad_one_q;
	logic pad_two_q;
	logic [aus_pkg::DAC_W-1:0] dac_q;

	// ****************************************
	// Special instruction decode
	// ****************************************
	// Control state lives only behind these opcodes, never on a data address
	logic run;
	logic ins;
	logic [NUM_CH-1:0] ch_sel;
	logic [NUM_CH-1:0] cfg_we;
	logic [NUM_CH-1:0] start_we;
	logic [NUM_CH-1:0] stop_we;
	logic [NUM_CH-1:0] env_we;
	assign run = (state_q == AUS_ST_RUN);
	assign ins = instr_in.valid && run; // RULE_14
	assign ch_sel = NUM_CH'(1) << instr_in.chan;
	assign cfg_we = (ins && instr_in.op == aus_pkg::AUS_OP_CFG) ? ch_sel : '0;
	assign start_we = (ins && instr_in.op == aus_pkg::AUS_OP_START) ? ch_sel : '0;
	assign stop_we = (ins && instr_in.op == aus_pkg::AUS_OP_STOP) ? ch_sel : '0;
	assign env_we = (ins && instr_in.op == aus_pkg::AUS_OP_ENV) ? ch_sel : '0;

	// ****************************************
	// Channels and shared ROM port
	// ****************************************
	logic [NUM_CH-1:0] req;
	logic [NUM_CH-1:0] grant;
	logic [NUM_CH-1:0] qio_stb;
	logic [aus_pkg::ADDR_W-1:0] addr [NUM_CH];
	logic signed [aus_pkg::SMP_W-1:0] smp [NUM_CH];
	logic [3:0] quick_io_code [NUM_CH];
	logic signed [aus_pkg::MIX_W-1:0] part [NUM_CH+1];
	logic [aus_pkg::ADDR_W-1:0] addr_sel [NUM_CH+1];
	logic [3:0] qio_sel [NUM_CH+1];
	logic busy;

	// One fetch in flight at a time; rates are far below the clock so fixed priority is fair
	assign busy = |valid_q;
	assign part[0] = '0;
	assign addr_sel[0] = '0;
	assign qio_sel[0] = '0;

	genvar g;
	generate
		for (g = 0; g < NUM_CH; g++)
		begin : gen_ch
			logic lower_req;
			if (g == 0)
				assign lower_req = 1'b0;
			else
				assign lower_req = |req[g-1:0];
			assign grant[g] = req[g] && !lower_req && !busy;
			assign addr_sel[g+1] = grant[g] ? addr[g] : addr_sel[g];
			assign qio_sel[g+1] = qio_stb[g] ? quick_io_code[g] : qio_sel[g];
			// Channels beyond the mix setting drop out of the sum
			assign part[g+1] = part[g] + ((g <= int'(mix_q)) ?
				aus_pkg::MIX_W'(smp[g]) : aus_pkg::MIX_W'(0)); // RULE_02
			aus_channel u_ch (
				.sys_clk_in(sys_clk_in),
				.rst_in(rst_in),
				.tick_in(tick_q),
				.cfg_we_in(cfg_we[g]),
				.start_we_in(start_we[g]),
				.stop_in(stop_we[g]),
				.env_we_in(env_we[g]),
				.arg_in(instr_in.arg),
				.grant_in(grant[g]),
				.rom_valid_in(valid_q[g]),
				.rom_data_in(rom_data_in),
				.play_flag_out(play_flag_out[g]),
				.rom_req_out(req[g]),
				.rom_addr_out(addr[g]),
				.sample_out(smp[g]),
				.quick_io_code_out(quick_io_code[g]),
				.quick_io_strobe_out(qio_stb[g])
			); // RULE_01 RULE_03 RULE_05
		end
	endgenerate

	assign rom_rd_out = |grant;
	assign rom_addr_out = addr_sel[NUM_CH];
	assign quick_io_code_out = qio_sel[NUM_CH];
	assign quick_io_strobe_out = |qio_stb;

	// ****************************************
	// Volume and output stages
	// ****************************************
	logic signed [aus_pkg::MIX_W+aus_pkg::VOL_W+1:0] scaled_full;
	logic signed [aus_pkg::MIX_W+1:0] scaled;
	logic [aus_pkg::DAC_W-1:0] sat;
	logic [aus_pkg::DAC_W-1:0] dac_d;
	logic [aus_pkg::PWM_W-1:0] duty;
	logic use_dac;
	// Step n gives gain (n+1)/16, so code 0 stays audible and 15 is full scale
	assign scaled_full = part[NUM_CH] * signed'({2'b00, vol_q} + 6'h01); // RULE_12 RULE_18
	assign scaled = scaled_full[aus_pkg::MIX_W+aus_pkg::VOL_W+1:aus_pkg::VOL_W];
	assign sat = (scaled > 13'sd511) ? aus_pkg::DAC_POS_MAX :
		(scaled < -13'sd512) ? aus_pkg::DAC_NEG_MAX : scaled[aus_pkg::DAC_W-1:0];
	assign dac_d = sat ^ aus_pkg::DAC_MID; // RULE_15
	assign duty = dac_d[aus_pkg::DAC_W-1:1]; // RULE_15
	assign use_dac = (aud_q == aus_pkg::AUS_OUT_DAC); // RULE_08

	assign audio_output_select_out = use_dac;
	assign detect_busy_out = !run;
	assign audio_pad_one_out = pad_one_q; // RULE_13
	assign audio_pad_two_out = pad_two_q; // RULE_13
	// Pad two is released while sensing, and in DAC mode it is strapped to the supply
	assign audio_pad_two_oe_n_out = !run || use_dac;
	assign pad_two_pulldown_out = !run;
	assign dac_enable_out = run && use_dac;
	assign dac_code_out = dac_q;

	// ****************************************
	// Reset pad detection and control state
	// ****************************************
	always_ff @(posedge sys_clk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			pad_meta_q <= 1'b0;
			pad_sync_q <= 1'b0;
		end
		else
		begin
			pad_meta_q <= audio_pad_two_in;
			pad_sync_q <= pad_meta_q;
		end
	end

	always_ff @(posedge sys_clk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			state_q <= AUS_ST_SENSE;
			det_cnt_q <= '0;
			aud_q <= aus_pkg::AUS_OUT_PWM;
			mix_q <= aus_pkg::MIX_RESET;
			vol_q <= aus_pkg::VOL_RESET;
		end
		else
		begin
			case (state_q)
				AUS_ST_SENSE:
				begin
					det_cnt_q <= det_cnt_q + 1'b1;
					if (det_cnt_q == ($clog2(DETECT_CYCLES+1))'(DETECT_CYCLES - 1))
					begin
						state_q <= AUS_ST_RUN;
						// A pulled-down floating pad reads low; a strap to supply reads high
						aud_q <= pad_sync_q ? aus_pkg::AUS_OUT_DAC : aus_pkg::AUS_OUT_PWM; // RULE_09 RULE_10
					end
				end
				default:
				begin
					if (ins && instr_in.op == aus_pkg::AUS_OP_AUD)
						aud_q <= aus_pkg::aus_out_t'(instr_in.arg[0]); // RULE_08
					if (ins && instr_in.op == aus_pkg::AUS_OP_MIX)
						mix_q <= instr_in.arg[1:0]; // RULE_02
					if (ins && instr_in.op == aus_pkg::AUS_OP_VOL)
						vol_q <= instr_in.arg[aus_pkg::VOL_W-1:0]; // RULE_18
				end
			endcase
		end
	end

	// ****************************************
	// Timer tick, fetch tracking and output registers
	// ****************************************
	always_ff @(posedge sys_clk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			div_q <= '0;
			tick_q <= 1'b0;
			valid_q <= '0;
			pwm_cnt_q <= '0;
			pad_one_q <= 1'b0;
			pad_two_q <= 1'b0;
			dac_q <= aus_pkg::DAC_MID;
		end
		else
		begin
			// Wrap on the count itself; wrapping on the tick would stretch each period by one
			tick_q <= (div_q == ($clog2(aus_pkg::TICK_DIV))'(aus_pkg::TICK_DIV - 1)); // RULE_03
			div_q <= (div_q == ($clog2(aus_pkg::TICK_DIV))'(aus_pkg::TICK_DIV - 1)) ? '0 :
				div_q + 1'b1;
			valid_q <= grant;
			pwm_cnt_q <= pwm_cnt_q + 1'b1;
			pad_one_q <= run && (use_dac ? 1'b0 : (pwm_cnt_q < duty)); // RULE_13
			pad_two_q <= run && !use_dac && !(pwm_cnt_q < duty);
			dac_q <= dac_d;
		end
	end
endmodule
`default_nettype wire

// [tb/aus_synth_asserts.sv]
// Port-level checks for the audio synthesizer top
`default_nettype none
module aus_synth_asserts #(
	parameter int NUM_CH = 4,
	parameter int DETECT_CYCLES = 16
) (
	input wire logic sys_clk_in,
	input wire logic rst_in,
	input wire aus_pkg::aus_instr_t instr_in,
	input wire logic rom_rd_out,
	input wire logic [aus_pkg::ADDR_W-1:0] rom_addr_out,
	input wire logic [NUM_CH-1:0] play_flag_out,
	input wire logic audio_output_select_out,
	input wire logic detect_busy_out,
	input wire logic audio_pad_one_out,
	input wire logic audio_pad_two_out,
	input wire logic audio_pad_two_oe_n_out,
	input wire logic pad_two_pulldown_out,
	input wire logic dac_enable_out
);
	timeunit 1ns;
	timeprecision 1ps;
	// ***
	// Helpers
	// ***
	logic [7:0] busy_q;
	wire take = instr_in.valid && !detect_busy_out;
	wire take_start = take && instr_in.op == aus_pkg::AUS_OP_START;
	wire take_stop = take && instr_in.op == aus_pkg::AUS_OP_STOP;
	wire take_aud = take && instr_in.op == aus_pkg::AUS_OP_AUD;
	// Saturates so a stuck sensing phase cannot wrap back under the bound
	always_ff @(posedge sys_clk_in or posedge rst_in)
		if (rst_in)
			busy_q <= 8'h00;
		else if (detect_busy_out && busy_q != 8'hff)
			busy_q <= busy_q + 8'h01;
	default clocking @(posedge sys_clk_in); endclocking
	default disable iff (rst_in);
	a_sense_pull: assert property (detect_busy_out |-> pad_two_pulldown_out && audio_pad_two_oe_n_out)
		else $error("pad two not released while sensing");
	a_sense_len: assert property (busy_q <= DETECT_CYCLES + 2)
		else $error("sensing phase too long");
	a_sense_refuse: assert property (detect_busy_out && instr_in.valid |=> $stable(play_flag_out))
		else $error("instruction taken while sensing");
	a_aud_select: assert property (take_aud |=> audio_output_select_out == $past(instr_in.arg[0]))
		else $error("output select not set");
	a_pwm_pads: assert property ((!audio_output_select_out && !detect_busy_out) [*3]
		|-> !audio_pad_two_oe_n_out && audio_pad_two_out != audio_pad_one_out)
		else $error("pwm pads not complementary");
	a_dac_pads: assert property (audio_output_select_out [*3]
		|-> !audio_pad_one_out && audio_pad_two_oe_n_out && dac_enable_out)
		else $error("dac mode pads wrong");
	a_start_flag: assert property (take_start |=> play_flag_out[$past(instr_in.chan)])
		else $error("play flag not set by start");
	a_start_fetch: assert property (take_start && play_flag_out == '0 && !rom_rd_out
		|=> rom_rd_out && rom_addr_out == $past(instr_in.arg))
		else $error("start fetch missing");
	a_stop_flag: assert property (take_stop |=> !play_flag_out[$past(instr_in.chan)])
		else $error("play flag not cleared by stop");
	a_rom_gap: assert property (rom_rd_out |=> !rom_rd_out)
		else $error("reads too close");
	c_start: cover property (take_start);
	c_aud_dac: cover property (take_aud && instr_in.arg[0]);
	c_sense_dac: cover property ($fell(detect_busy_out) ##1 audio_output_select_out);
endmodule
bind aus_synth aus_synth_asserts #(.NUM_CH(NUM_CH), .DETECT_CYCLES(DETECT_CYCLES)) i_chk (
	.sys_clk_in, .rst_in, .instr_in, .rom_rd_out, .rom_addr_out, .play_flag_out,
	.audio_output_select_out, .detect_busy_out, .audio_pad_one_out, .audio_pad_two_out,
	.audio_pad_two_oe_n_out, .pad_two_pulldown_out, .dac_enable_out);
`default_nettype wire

// [tb/aus_pad_model.sv]
// Far side of the pads: speaker across both pads, or pad two strapped high
`default_nettype none
module aus_pad_model (
	input wire logic sys_clk_in,
	input wire logic tie_high_in,
	input wire logic drive_in,
	input wire logic oe_n_in,
	input wire logic pulldown_in,
	output logic level_out
);
	timeunit 1ns;
	timeprecision 1ps;
	logic last_q = 1'b0;
	// Floating and unpulled: show the opposite of the last level, never a held value
	always_comb
		if (tie_high_in)
			level_out = 1'b1;
		else if (!oe_n_in)
			level_out = drive_in;
		else if (pulldown_in)
			level_out = 1'b0;
		else
			level_out = ~last_q;
	always @(posedge sys_clk_in)
		last_q <= level_out;
endmodule
`default_nettype wire

// [tb/tb_aus_synth.sv]
// Self-checking bench for the audio synthesizer top
`default_nettype none
module tb_aus_synth;
	timeunit 1ns;
	timeprecision 1ps;
	// ***
	// Signals and instances
	// ***
	localparam int DET = 4;
	logic sys_clk_in = 1'b0;
	logic rst_in = 1'b1;
	logic tie_high = 1'b0;
	logic rd_q = 1'b0;
	logic [17:0] addr_q = '0;
	logic [9:0] rom_data = '0;
	logic [9:0] mem [0:63];
	logic [3:0] qio_seen = '0;
	aus_pkg::aus_instr_t instr = '0;
	logic rom_rd, qio_stb, sel, busy, pad_one, pad_lvl, pad_drv, oe_n, pull, dac_en;
	logic [17:0] rom_addr;
	logic [3:0] flags, quick_io_code;
	logic [9:0] dac;
	int bad_count = 0;
	int cmp_count = 0;
	int cyc = 0;
	aus_synth #(.DETECT_CYCLES(DET)) i_dut (.sys_clk_in, .rst_in, .instr_in(instr),
		.rom_rd_out(rom_rd), .rom_addr_out(rom_addr), .rom_data_in(rom_data),
		.play_flag_out(flags), .quick_io_code_out(quick_io_code), .quick_io_strobe_out(qio_stb),
		.audio_output_select_out(sel), .detect_busy_out(busy), .audio_pad_one_out(pad_one),
		.audio_pad_two_in(pad_lvl), .audio_pad_two_out(pad_drv), .audio_pad_two_oe_n_out(oe_n),
		.pad_two_pulldown_out(pull), .dac_enable_out(dac_en), .dac_code_out(dac));
	aus_pad_model i_pad (.sys_clk_in, .tie_high_in(tie_high), .drive_in(pad_drv),
		.oe_n_in(oe_n), .pulldown_in(pull), .level_out(pad_lvl));
	always #12.5 sys_clk_in = ~sys_clk_in;
	always @(posedge sys_clk_in)
	begin
		rd_q <= rom_rd;
		addr_q <= rom_addr;
		if (qio_stb === 1'b1)
			qio_seen <= quick_io_code;
		cyc <= cyc + 1;
		// Whole run needs about 6000 cycles
		if (cyc == 20000)
		begin
			bad_count++;
			complete_run();
		end
	end
	// ROM answers one cycle after the read; idle cycles show a changing word
	always @(negedge sys_clk_in)
		rom_data <= rd_q ? mem[addr_q[5:0]] : ~rom_data;
	// ***
	// Tasks
	// ***
	task automatic complete_run();
		if (bad_count == 0 && cmp_count > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [17:0] exp, input logic [17:0] got);
		cmp_count++;
		if (got !== exp)
		begin
			bad_count++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic op(input aus_pkg::aus_op_t o, input logic [1:0] ch, input logic [17:0] a);
		@(negedge sys_clk_in);
		instr = {1'b1, o, ch, a};
		@(negedge sys_clk_in);
		instr.valid = 1'b0;
	endtask
	task automatic wait_flag(input int ch, input logic v);
		int n = 0;
		while (flags[ch] !== v && n < 3000)
		begin
			@(negedge sys_clk_in);
			n++;
		end
		chk("play flag", v, flags[ch]);
	endtask
	task automatic do_reset(input logic th);
		int n = 0;
		tie_high = th;
		rst_in = 1'b1;
		repeat (4) @(negedge sys_clk_in);
		rst_in = 1'b0;
		// A start offered during sensing must be dropped
		instr = {1'b1, aus_pkg::AUS_OP_START, 2'h0, 18'h00000};
		while (busy !== 1'b0 && n < 50)
		begin
			@(negedge sys_clk_in);
			instr.valid = 1'b0;
			n++;
		end
		chk("sense length", 1'b1, n >= DET && n <= DET + 3);
		chk("select", th, sel);
		chk("refused start", 1'b0, flags[0]);
	endtask
	// ***
	// Scenarios
	// ***
	initial
	begin
		logic [9:0] vexp [3] = '{10'h280, 10'h240, 10'h208};
		logic [3:0] vcode [3] = '{4'hf, 4'h7, 4'h0};
		foreach (mem[i]) mem[i] = 10'h000;
		mem[0] = 10'h3ea;
		mem[1] = 10'h100;
		mem[3] = 10'h3ff;
		// A skip of one steps over the end marks at 9 and 11
		mem[8] = 10'h100;
		mem[9] = 10'h3ff;
		mem[10] = 10'h180;
		mem[11] = 10'h3ff;
		mem[12] = 10'h3ff;
		// ADPCM: +15 with step up, -6 with step down, then -9
		mem[16] = 10'h007;
		mem[17] = 10'h009;
		mem[18] = 10'h00c;
		mem[19] = 10'h3ff;
		do_reset(1'b0);
		chk("pad two oe_n", 1'b0, oe_n);
		op(aus_pkg::AUS_OP_CFG, 2'h0, 18'h00017);
		op(aus_pkg::AUS_OP_START, 2'h0, 18'h00000);
		repeat (8) @(negedge sys_clk_in);
		chk("quick io", 4'ha, qio_seen);
		chk("play flag", 1'b1, flags[0]);
		// Sample 128 held; gain is (code+1)/16
		for (int i = 0; i < 3; i++)
		begin
			op(aus_pkg::AUS_OP_VOL, 2'h0, 18'(vcode[i]));
			repeat (6) @(negedge sys_clk_in);
			chk("volume dac", vexp[i], dac);
		end
		op(aus_pkg::AUS_OP_VOL, 2'h0, 18'h0000f);
		wait_flag(0, 1'b0);
		repeat (4) @(negedge sys_clk_in);
		chk("idle dac", 10'h200, dac);
		op(aus_pkg::AUS_OP_CFG, 2'h0, 18'h01017);
		op(aus_pkg::AUS_OP_START, 2'h0, 18'h00010);
		repeat (8) @(negedge sys_clk_in);
		chk("adpcm first", 10'h20f, dac);
		// Second sample lands about 920 cycles after start, the third about 1840
		repeat (1300) @(negedge sys_clk_in);
		chk("adpcm second", 10'h209, dac);
		wait_flag(0, 1'b0);
		chk("adpcm end", 10'h200, dac);
		op(aus_pkg::AUS_OP_CFG, 2'h1, 18'h02117);
		op(aus_pkg::AUS_OP_ENV, 2'h1, 18'h00080);
		op(aus_pkg::AUS_OP_START, 2'h1, 18'h00008);
		repeat (8) @(negedge sys_clk_in);
		chk("melody dac", 10'h240, dac);
		op(aus_pkg::AUS_OP_MIX, 2'h0, 18'h00000);
		repeat (6) @(negedge sys_clk_in);
		chk("mix one", 10'h200, dac);
		op(aus_pkg::AUS_OP_MIX, 2'h0, 18'h00001);
		repeat (6) @(negedge sys_clk_in);
		chk("mix two", 10'h240, dac);
		// Second melody sample comes from word 10: 192 * 128 / 256
		repeat (1300) @(negedge sys_clk_in);
		chk("melody skip", 10'h260, dac);
		op(aus_pkg::AUS_OP_STOP, 2'h1, 18'h00000);
		wait_flag(1, 1'b0);
		op(aus_pkg::AUS_OP_AUD, 2'h0, 18'h00001);
		repeat (4) @(negedge sys_clk_in);
		chk("select dac", 1'b1, sel);
		chk("dac enable", 1'b1, dac_en);
		chk("pad one", 1'b0, pad_one);
		op(aus_pkg::AUS_OP_AUD, 2'h0, 18'h00000);
		repeat (4) @(negedge sys_clk_in);
		chk("pwm oe_n", 1'b0, oe_n);
		do_reset(1'b1);
		complete_run();
	end
endmodule
`default_nettype wire
